/* hw/sdiu_divider.sv */
// Combinational signed divider of parameterised width with flag outputs
`timescale 1ns/10ps
module sdiu_divider #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic      [W-1:0] quotient,
  output logic      [W-1:0] remainder,
  output logic              div_by_zero,
  output logic              overflow
);
  import sdiu_pkg::*;

  logic signed [W:0] a;
  logic signed [W:0] b;
  logic signed [W:0] q;
  logic signed [W:0] r;

  // One extra bit keeps most-negative by minus one from overflowing; low bits wrap
  // truncating signed divide
  always_comb begin
    a = {dividend[W-1], dividend};
    b = {divisor[W-1], divisor};
    q = '0;
    r = '0;
    if (b != '0) begin
      q = a / b;
      r = a % b;
    end
  end

  assign quotient    = q[W-1:0];
  assign remainder   = r[W-1:0];
  assign div_by_zero = (divisor == '0);
  assign overflow    = (dividend == {1'b1, {(W-1){1'b0}}}) && (divisor == {W{1'b1}});

endmodule // sdiu_divider

/* hw/sdiu_pkg.sv */
// Shared constants, types and helpers of the signed divide and increment unit
//
// How it works
// - Quotient and remainder carry their sign in the top bit, 1 meaning negative.
// - Quotient is negative when exactly one operand is negative.
// - Remainder takes the sign of the dividend.
// - Digit-group destination receives only the quotient, never a remainder.
// - Zero flag is set when the division result is zero.
// - 16-bit carry only for -32,768 divided by -1.
// - 32-bit carry only for -2,147,483,648 divided by -1.
// - Increment adds one to the destination and writes it back there.
// - Increment works on 16-bit words or 32-bit values per form.
// - Continuous form adds every enabled scan; single-shot once per activation.
// - 16-bit increment of +32,767 wraps to -32,768.
// - 32-bit increment of +2,147,483,647 wraps to -2,147,483,648.
// - Increment never touches the zero, borrow or carry flags.
// - Quotient goes to the destination, remainder to the following word or pair.
// - Zero flag is cleared when the division result is nonzero.
package sdiu_pkg;

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          SDIU_W16      = 16;
  localparam int          SDIU_W32      = 32;
  localparam logic [15:0] SDIU_ONE16    = 16'h0001;
  localparam logic [31:0] SDIU_ONE32    = 32'h0000_0001;
  localparam logic [15:0] SDIU_UPPER0   = 16'h0000;
  localparam logic        SDIU_FLAG_RST = 1'b0;
  localparam logic [31:0] SDIU_DATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Operations and carriers
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDIU_OP_DIV16,
    SDIU_OP_DIV32,
    SDIU_OP_INC16,
    SDIU_OP_INC32
  } sdiu_op_t;

  typedef struct packed {
    sdiu_op_t    op;
    logic        single_shot;
    logic        dest_digit_group;
    logic        dest_index2;
    logic [31:0] first_source_operand;
    logic [31:0] second_source_operand;
    logic [31:0] dest_value;
  } sdiu_req_t;

  typedef struct packed {
    logic [31:0] main_word;
    logic [31:0] remainder;
    logic        write_main;
    logic        write_remainder;
  } sdiu_res_t;

  // Magnitude of a signed 32-bit value, one bit wider so -2^31 fits
  function automatic logic [32:0] sdiu_abs32(input logic [31:0] v);
    logic [32:0] ext;
    ext = {v[31], v};
    sdiu_abs32 = v[31] ? (33'h0 - ext) : ext;
  endfunction

endpackage

/* hw/sdiu_top.sv */
// Signed divide and increment execution unit, one operation per scan tick
`timescale 1ns/10ps
module sdiu_top (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               scan_tick,
  input  wire logic               exec_condition,
  input  wire sdiu_pkg::sdiu_req_t req,
  output sdiu_pkg::sdiu_res_t     result,
  output logic                    result_valid,
  output logic                    refused,
  output logic                    zero_result_flag,
  output logic                    overflow_carry_flag,
  output logic                    execution_state_out
);
  import sdiu_pkg::*;

  // ---------------------------------------------------------------------------
  // Divider instances
  // ---------------------------------------------------------------------------
  logic [15:0] q16;
  logic [15:0] r16;
  logic        dz16;
  logic        ov16;
  logic [31:0] q32;
  logic [31:0] r32;
  logic        dz32;
  logic        ov32;

  sdiu_divider #(.W(SDIU_W16)) u_div16 (
    .dividend    (req.first_source_operand[15:0]),
    .divisor     (req.second_source_operand[15:0]),
    .quotient    (q16),
    .remainder   (r16),
    .div_by_zero (dz16),
    .overflow    (ov16)
  );

  sdiu_divider #(.W(SDIU_W32)) u_div32 (
    .dividend    (req.first_source_operand),
    .divisor     (req.second_source_operand),
    .quotient    (q32),
    .remainder   (r32),
    .div_by_zero (dz32),
    .overflow    (ov32)
  );

  // ---------------------------------------------------------------------------
  // Activation and refusal
  // ---------------------------------------------------------------------------
  logic prev_cond;
  logic is_div;
  logic run;
  logic bad;
  logic fire;

  // Condition history is only sampled on scan ticks so single-shot spans a scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_cond <= SDIU_FLAG_RST;
    end else if (ce && scan_tick) begin
      prev_cond <= exec_condition;
    end
  end

  assign is_div = (req.op == SDIU_OP_DIV16) || (req.op == SDIU_OP_DIV32);
  assign run    = ce && scan_tick && exec_condition && (!req.single_shot || !prev_cond);
  // refuse index2 for 32-bit division; divide by zero also refused
  assign bad    = ((req.op == SDIU_OP_DIV16) && dz16) ||
                  ((req.op == SDIU_OP_DIV32) && (dz32 || req.dest_index2));
  assign fire   = run && !bad;

  // ---------------------------------------------------------------------------
  // Next result
  // ---------------------------------------------------------------------------
  sdiu_res_t next_result;
  logic      next_zero;
  logic      next_carry;

  // Operands narrower than 32 bits sit in the low half, upper half reads zero
  always_comb begin
    next_result = '0;
    next_zero   = SDIU_FLAG_RST;
    next_carry  = SDIU_FLAG_RST;
    unique case (req.op)
      SDIU_OP_DIV16: begin
        next_result.main_word       = {SDIU_UPPER0, q16};
        next_result.remainder       = {SDIU_UPPER0, r16};
        next_result.write_main      = 1'b1;
        next_result.write_remainder = !req.dest_digit_group;
        next_zero                   = (q16 == SDIU_UPPER0);
        next_carry                  = ov16;
      end
      SDIU_OP_DIV32: begin
        next_result.main_word       = q32;
        next_result.remainder       = r32;
        next_result.write_main      = 1'b1;
        next_result.write_remainder = !req.dest_digit_group;
        next_zero                   = (q32 == SDIU_DATA_RST);
        next_carry                  = ov32;
      end
      SDIU_OP_INC16: begin
        next_result.main_word  = {SDIU_UPPER0, req.dest_value[15:0] + SDIU_ONE16};
        next_result.write_main = 1'b1;
      end
      SDIU_OP_INC32: begin
        next_result.main_word  = req.dest_value + SDIU_ONE32;
        next_result.write_main = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------------------
  // Data holds between executions; write strobes last one enabled cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else if (ce) begin
      if (fire) begin
        result <= next_result;
      end else begin
        result.write_main      <= 1'b0;
        result.write_remainder <= 1'b0;
      end
    end
  end

  // Handshake pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= SDIU_FLAG_RST;
      refused      <= SDIU_FLAG_RST;
    end else if (ce) begin
      result_valid <= fire;
      refused      <= run && bad;
    end
  end

  // Execution state is a level that stands for one whole scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      execution_state_out <= SDIU_FLAG_RST;
    end else if (ce && scan_tick) begin
      execution_state_out <= fire;
    end
  end

  // Flags move only on a completed division; a refused one leaves them alone
  // increments never reach here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_result_flag    <= SDIU_FLAG_RST;
      overflow_carry_flag <= SDIU_FLAG_RST;
    end else if (fire && is_div) begin
      zero_result_flag    <= next_zero;
      overflow_carry_flag <= next_carry;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_quot_sign32;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_DIV32) && !overflow_carry_flag |->
      result.main_word[31] == (($past(req.first_source_operand[31]) ^ $past(req.second_source_operand[31]))
                               && (result.main_word != SDIU_DATA_RST));
  endproperty
  a_quot_sign32: assert property (p_quot_sign32) else $error("32-bit quotient sign wrong");

  property p_quot_sign16;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_DIV16) && !overflow_carry_flag |->
      result.main_word[15] == (($past(req.first_source_operand[15]) ^ $past(req.second_source_operand[15]))
                               && (result.main_word[15:0] != SDIU_UPPER0));
  endproperty
  a_quot_sign16: assert property (p_quot_sign16) else $error("16-bit quotient sign wrong");

  property p_rem_sign;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_DIV32) |->
      result.remainder[31] == ($past(req.first_source_operand[31]) && (result.remainder != SDIU_DATA_RST));
  endproperty
  a_rem_sign: assert property (p_rem_sign) else $error("remainder sign differs from dividend");

  property p_digit_norem;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && $past(is_div) |->
      result.write_main && (result.write_remainder == !$past(req.dest_digit_group));
  endproperty
  a_digit_norem: assert property (p_digit_norem) else $error("remainder write wrong");

  property p_index2_refused;
    @(posedge clk) disable iff (!rst_n)
    run && (req.op == SDIU_OP_DIV32) && req.dest_index2 |=> refused && !result_valid && !result.write_main;
  endproperty
  a_index2_refused: assert property (p_index2_refused) else $error("index2 destination accepted");

  property p_zero_flag;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && $past(is_div) |-> zero_result_flag == (result.main_word == SDIU_DATA_RST);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with quotient");

  property p_carry16;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_DIV16) |->
      overflow_carry_flag == (($past(req.first_source_operand[15:0]) == 16'h8000) &&
                              ($past(req.second_source_operand[15:0]) == 16'hffff));
  endproperty
  a_carry16: assert property (p_carry16) else $error("16-bit carry wrong");

  property p_carry32;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_DIV32) |->
      overflow_carry_flag == (($past(req.first_source_operand) == 32'h8000_0000) &&
                              ($past(req.second_source_operand) == 32'hffff_ffff));
  endproperty
  a_carry32: assert property (p_carry32) else $error("32-bit carry wrong");

  property p_trunc;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_DIV32) |->
      sdiu_abs32(result.remainder) < sdiu_abs32($past(req.second_source_operand));
  endproperty
  a_trunc: assert property (p_trunc) else $error("remainder not below divisor");

  property p_inc16;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_INC16) && ($past(req.dest_value[15:0]) == 16'h7fff) |->
      result.main_word == 32'h0000_8000;
  endproperty
  a_inc16: assert property (p_inc16) else $error("16-bit increment wrap wrong");

  property p_inc32;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && ($past(req.op) == SDIU_OP_INC32) && ($past(req.dest_value) == 32'h7fff_ffff) |->
      result.main_word == 32'h8000_0000;
  endproperty
  a_inc32: assert property (p_inc32) else $error("32-bit increment wrap wrong");

  property p_inc_flags;
    @(posedge clk) disable iff (!rst_n)
    $past(fire) && !$past(is_div) |-> $stable(zero_result_flag) && $stable(overflow_carry_flag)
      && !result.write_remainder;
  endproperty
  a_inc_flags: assert property (p_inc_flags) else $error("increment changed flags");

  property p_single_shot;
    @(posedge clk) disable iff (!rst_n)
    ce && scan_tick && exec_condition && req.single_shot && prev_cond |=> !result_valid && !result.write_main;
  endproperty
  a_single_shot: assert property (p_single_shot) else $error("single-shot repeated");

endmodule // sdiu_top

/* sim/sdiu_bench.sv */
// Self-checking bench of the divide and increment unit against an integer model
`timescale 1ns/10ps
module sdiu_bench;
  import sdiu_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        scan_tick;
  logic        exec_condition;
  sdiu_req_t   req;
  sdiu_res_t   result;
  logic        result_valid;
  logic        refused;
  logic        zero_result_flag;
  logic        overflow_carry_flag;
  logic        execution_state_out;
  int          fail_count = 0;
  int          checked = 0;
  int          seed = 55038;
  logic [31:0] e_main;
  logic [31:0] e_rem;
  logic [31:0] e_msk;
  logic        e_wr;
  logic        e_ref;
  logic        e_z = 1'b0;
  logic        e_c = 1'b0;
  logic [31:0] exp_q[$];       // Expected destination words, oldest first

  always #50 clk = ~clk;

  sdiu_top i_sdiu_top (.clk(clk), .rst_n(rst_n), .ce(ce), .scan_tick(scan_tick),
    .exec_condition(exec_condition), .req(req), .result(result), .result_valid(result_valid),
    .refused(refused), .zero_result_flag(zero_result_flag), .overflow_carry_flag(overflow_carry_flag),
    .execution_state_out(execution_state_out));

  sdiu_sequencer i_sdiu_sequencer (.clk(clk), .scan_tick(scan_tick), .exec_condition(exec_condition),
    .req(req));

  // ---------------------------------------------------------------------------
  // Compare, verdict and reference model
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Longint keeps most-negative by minus one exact before wrapping
  task automatic model(input sdiu_req_t q);
    longint a;
    longint b;
    longint d;
    longint m;
    logic   s16;
    s16 = (q.op == SDIU_OP_DIV16) || (q.op == SDIU_OP_INC16);
    a = s16 ? longint'($signed(q.first_source_operand[15:0])) : longint'($signed(q.first_source_operand));
    b = s16 ? longint'($signed(q.second_source_operand[15:0])) : longint'($signed(q.second_source_operand));
    e_msk = s16 ? 32'h0000_ffff : 32'hffff_ffff;
    if (q.op == SDIU_OP_INC16) begin
      e_main = {16'h0000, q.dest_value[15:0] + 16'h0001};
    end else if (q.op == SDIU_OP_INC32) begin
      e_main = q.dest_value + 32'h0000_0001;
    end else if (b == 0 || (q.op == SDIU_OP_DIV32 && q.dest_index2)) begin
      e_ref = 1'b1;
    end else begin
      d = a / b;
      m = a % b;
      e_c = s16 ? (d == 32768) : (d == 64'sd2147483648);
      e_main = s16 ? {16'h0000, d[15:0]} : d[31:0];
      e_rem = m[31:0];
      e_z = (e_main == 32'h0000_0000);
      e_wr = !q.dest_digit_group;
    end
    // Only accepted executions write the destination
    if (!e_ref) begin
      exp_q.push_back(e_main);
    end
  endtask

  // One scan through the sequencer; f is single shot, digit group, index destination
  task automatic t(input sdiu_op_t o, input logic [31:0] a, input logic [31:0] b, input logic [31:0] dv,
                   input logic [2:0] f, input logic cond, input logic runs);
    sdiu_req_t q;
    logic      g;
    q = '{op: o, single_shot: f[2], dest_digit_group: f[1], dest_index2: f[0],
          first_source_operand: a, second_source_operand: b, dest_value: dv};
    i_sdiu_sequencer.tick(q, cond, f[0]);
    #1;
    g = cond & runs;
    e_ref = 1'b0;
    e_wr = 1'b0;
    if (g) begin
      model(req);
    end
    chk("refused", 32'(refused), 32'(g & e_ref));
    g = g & !e_ref;
    chk("result_valid", 32'(result_valid), 32'(g));
    chk("execution_state_out", 32'(execution_state_out), 32'(g));
    chk("write_main", 32'(result.write_main), 32'(g));
    chk("write_remainder", 32'(result.write_remainder), 32'(g & e_wr));
    chk("zero_result_flag", 32'(zero_result_flag), 32'(e_z));
    chk("overflow_carry_flag", 32'(overflow_carry_flag), 32'(e_c));
    if (g) begin
      chk("main_word", result.main_word, exp_q.pop_front());
    end
    if (g & e_wr) begin
      chk("remainder", result.remainder & e_msk, e_rem & e_msk);
    end
  endtask

  // Hang guard ends the run through the same verdict
  initial begin
    #2_000_000;
    fail_count++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t(SDIU_OP_DIV16, 32'h0000_0024, 32'h0000_fffb, 32'h0, 3'b000, 1'b0, 1'b0); // Quiet after reset
    t(SDIU_OP_DIV16, 32'h0000_0024, 32'h0000_fffb, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'h0000_ffdc, 32'h0000_0005, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'h0000_8000, 32'h0000_ffff, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'h0000_0007, 32'h0000_0003, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'h0000_0003, 32'h0000_0007, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV32, 32'h8000_0000, 32'hffff_ffff, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV32, 32'h0000_157c, 32'hffff_fde4, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'habcd_0010, 32'h1234_0002, 32'h0, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'h0000_0064, 32'h0000_0007, 32'h0, 3'b010, 1'b1, 1'b1);
    t(SDIU_OP_DIV32, 32'h0000_0064, 32'h0000_0007, 32'h0, 3'b001, 1'b1, 1'b1);
    t(SDIU_OP_DIV16, 32'h0000_0064, 32'h0000_0000, 32'h0, 3'b000, 1'b1, 1'b1); // Divide by zero kept out
    t(SDIU_OP_INC16, 32'h0, 32'h0, 32'hffff_7fff, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_INC32, 32'h0, 32'h0, 32'h7fff_ffff, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_INC16, 32'h0, 32'h0, 32'h0000_0005, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_INC16, 32'h0, 32'h0, 32'h0000_0006, 3'b000, 1'b1, 1'b1);
    t(SDIU_OP_INC32, 32'h0, 32'h0, 32'h0000_0009, 3'b100, 1'b1, 1'b0); // held edge ignored
    t(SDIU_OP_INC32, 32'h0, 32'h0, 32'h0000_0009, 3'b100, 1'b0, 1'b0); // condition released
    // Clock enable low freezes the edge memory, so the next activation still counts
    ce <= 1'b0;
    t(SDIU_OP_INC32, 32'h0, 32'h0, 32'h0000_0009, 3'b100, 1'b1, 1'b0); // frozen
    ce <= 1'b1;
    t(SDIU_OP_INC32, 32'h0, 32'h0, 32'h0000_0009, 3'b100, 1'b1, 1'b1); // new activation
    t(SDIU_OP_INC32, 32'h0, 32'h0, 32'h0000_000a, 3'b100, 1'b1, 1'b0);
    // random mix, small divisors make remainders likely
    for (int i = 0; i < 40; i++) begin
      t(sdiu_op_t'(2'($random(seed))), $random(seed), $random(seed) >>> (5'($random(seed)) | 5'h10),
        $random(seed), {1'b0, 1'($random(seed)), 1'b0}, 1'b1, 1'b1);
    end
    end_of_test();
  end
endmodule // sdiu_bench

/* sim/sdiu_sequencer.sv */
// Instruction sequencer model presenting operands and the execution condition
`timescale 1ns/10ps
module sdiu_sequencer (
  input  wire logic                clk,
  output logic                     scan_tick,
  output logic                     exec_condition,
  output sdiu_pkg::sdiu_req_t      req
);
  import sdiu_pkg::*;

  // Idle before the first scan so reset sees quiet inputs
  initial begin
    scan_tick = 1'b0;
    exec_condition = 1'b0;
    req = '0;
  end

  // ---------------------------------------------------------------------------
  // One scan: scan_tick high for exactly one cycle; operands and condition held until the next scan
  // ---------------------------------------------------------------------------
  task automatic tick(input sdiu_req_t q, input logic cond, input logic bad);
    @(posedge clk);
    if (q.op == SDIU_OP_DIV32 && !bad) begin
      q.dest_index2 = 1'b0; // Only a deliberate misuse reaches the unit
    end
    scan_tick <= 1'b1;
    exec_condition <= cond;
    req <= q;
    @(posedge clk);
    scan_tick <= 1'b0;
  endtask
endmodule // sdiu_sequencer
